// [hdl/ppm_pin_mux.sv]
// Port 1/2/3 pin function multiplexer with AXI4-Lite control registers
module ppm_pin_mux
  import ppm_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                ce_i,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  output logic [1:0]               s_axi_bresp_o,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  input  wire logic [N_PIN-1:0]    pin_in_i,
  output logic [N_PIN-1:0]         pin_out_o,
  output logic [N_PIN-1:0]         pin_oe_o,
  input  wire logic [N_FUNC-1:0]   periph_out_i,
  input  wire logic [N_FUNC-1:0]   periph_oe_i,
  output logic [N_FUNC-1:0]        periph_in_o,
  output logic [N_IRQ-1:0]         irq_o
);

  // Route table: {valid, function index}
  function automatic logic [FW:0] pin_route(input logic [3:0] pin, input logic [4:0] code);
    case ({pin, code})
      {PIN_P13, CODE_MT1}: pin_route = {1'b1, F_CH0_B};
      {PIN_P13, CODE_TMR}: pin_route = {1'b1, F_T3_OUT};
      {PIN_P13, CODE_IIC}: pin_route = {1'b1, F_SDA};
      {PIN_P14, CODE_MT1}: pin_route = {1'b1, F_CH3_A};
      {PIN_P14, CODE_MT2}: pin_route = {1'b1, F_CLK_A};
      {PIN_P14, CODE_TMR}: pin_route = {1'b1, F_T2_RST};
      {PIN_P14, CODE_SCB}: pin_route = {1'b1, F_S1_FLOW};
      {PIN_P14, CODE_TS }: pin_route = {1'b1, F_TS6};
      {PIN_P14, CODE_CAN}: pin_route = {1'b1, F_CAN_TX};
      {PIN_P15, CODE_MT1}: pin_route = {1'b1, F_CH0_B};
      {PIN_P15, CODE_MT2}: pin_route = {1'b1, F_CLK_B};
      {PIN_P15, CODE_TMR}: pin_route = {1'b1, F_T2_CNT};
      {PIN_P15, CODE_SCA}: pin_route = {1'b1, F_S1_RX};
      {PIN_P15, CODE_TS }: pin_route = {1'b1, F_TS5};
      {PIN_P15, CODE_CAN}: pin_route = {1'b1, F_CAN_RX};
      {PIN_P16, CODE_MT1}: pin_route = {1'b1, F_CH3_C};
      {PIN_P16, CODE_MT2}: pin_route = {1'b1, F_CH3_D};
      {PIN_P16, CODE_TMR}: pin_route = {1'b1, F_T2_OUT};
      {PIN_P16, CODE_ALT}: pin_route = {1'b1, F_RTC};
      {PIN_P16, CODE_ADT}: pin_route = {1'b1, F_ADTRG};
      {PIN_P16, CODE_SCA}: pin_route = {1'b1, F_S1_TX};
      {PIN_P16, CODE_SPI}: pin_route = {1'b1, F_SPI_MO};
      {PIN_P16, CODE_IIC}: pin_route = {1'b1, F_SCL};
      {PIN_P17, CODE_MT1}: pin_route = {1'b1, F_CH3_A};
      {PIN_P17, CODE_MT2}: pin_route = {1'b1, F_CH3_B};
      {PIN_P17, CODE_TMR}: pin_route = {1'b1, F_T1_OUT};
      {PIN_P17, CODE_ALT}: pin_route = {1'b1, F_ODIS8};
      {PIN_P17, CODE_SCA}: pin_route = {1'b1, F_S1_CLK};
      {PIN_P17, CODE_SPI}: pin_route = {1'b1, F_SPI_MI};
      {PIN_P17, CODE_IIC}: pin_route = {1'b1, F_SDA};
      {PIN_P20, CODE_MT1}: pin_route = {1'b1, F_CH1_A};
      {PIN_P20, CODE_TMR}: pin_route = {1'b1, F_T0_RST};
      {PIN_P21, CODE_MT1}: pin_route = {1'b1, F_CH1_B};
      {PIN_P21, CODE_TMR}: pin_route = {1'b1, F_T0_CNT};
      {PIN_P26, CODE_MT1}: pin_route = {1'b1, F_CH2_A};
      {PIN_P26, CODE_TMR}: pin_route = {1'b1, F_T1_OUT};
      {PIN_P26, CODE_SCA}: pin_route = {1'b1, F_S1_TX};
      {PIN_P26, CODE_TS }: pin_route = {1'b1, F_TS4};
      {PIN_P26, CODE_LPT}: pin_route = {1'b1, F_LOWPOWER_TIMER_OUTPUT};
      {PIN_P27, CODE_MT1}: pin_route = {1'b1, F_CH2_B};
      {PIN_P27, CODE_TMR}: pin_route = {1'b1, F_T3_CNT};
      {PIN_P27, CODE_SCA}: pin_route = {1'b1, F_S1_CLK};
      {PIN_P27, CODE_TS }: pin_route = {1'b1, F_TS3};
      {PIN_P30, CODE_MT1}: pin_route = {1'b1, F_CH4_B};
      {PIN_P30, CODE_TMR}: pin_route = {1'b1, F_T3_RST};
      {PIN_P30, CODE_ALT}: pin_route = {1'b1, F_ODIS8};
      {PIN_P30, CODE_SCA}: pin_route = {1'b1, F_S1_RX};
      {PIN_P30, CODE_TS }: pin_route = {1'b1, F_TS2};
      {PIN_P31, CODE_MT1}: pin_route = {1'b1, F_CH4_D};
      {PIN_P31, CODE_TMR}: pin_route = {1'b1, F_T2_CNT};
      {PIN_P31, CODE_SCA}: pin_route = {1'b1, F_S1_FLOW};
      {PIN_P31, CODE_TS }: pin_route = {1'b1, F_TS1};
      {PIN_P32, CODE_MT1}: pin_route = {1'b1, F_CH0_C};
      {PIN_P32, CODE_TMR}: pin_route = {1'b1, F_T3_OUT};
      {PIN_P32, CODE_ALT}: pin_route = {1'b1, F_RTC};
      {PIN_P32, CODE_SCB}: pin_route = {1'b1, F_S6_TX};
      {PIN_P32, CODE_TS }: pin_route = {1'b1, F_TS0};
      {PIN_P34, CODE_MT1}: pin_route = {1'b1, F_CH0_A};
      {PIN_P34, CODE_TMR}: pin_route = {1'b1, F_T3_CNT};
      {PIN_P34, CODE_ALT}: pin_route = {1'b1, F_ODIS2};
      {PIN_P34, CODE_SCB}: pin_route = {1'b1, F_S6_CLK};
      default:             pin_route = {1'b0, F_CH0_A};
    endcase
  endfunction : pin_route

  // Interrupt line of a port 3 pin: {valid, irq number}
  function automatic logic [3:0] pin_irq(input logic [3:0] pin);
    case (pin)
      PIN_P30: pin_irq = 4'h8;
      PIN_P31: pin_irq = 4'h9;
      PIN_P32: pin_irq = 4'hA;
      PIN_P34: pin_irq = 4'hC;
      PIN_P36: pin_irq = 4'hA;
      PIN_P37: pin_irq = 4'hC;
      default: pin_irq = 4'h0;
    endcase
  endfunction : pin_irq

  // Word address decode: {hit, pin index}
  function automatic logic [4:0] reg_decode(input logic [AXI_AW-1:0] addr);
    logic [AXI_AW-1:0] off;
    off = addr - REG_BASE;
    reg_decode = {(off >> REG_SHIFT) < AXI_AW'(N_PIN), 4'(off >> REG_SHIFT)};
  endfunction : reg_decode

  logic [7:0]          ctrl_reg [N_PIN];
  ppm_wr_state_t       wr_state_reg;
  ppm_rd_state_t       rd_state_reg;
  logic                aw_held_reg, w_held_reg;
  logic [AXI_AW-1:0]   awaddr_reg;
  logic [7:0]          wdata_reg;
  logic                wstrb0_reg;
  logic                awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]          bresp_reg, rresp_reg;
  logic [31:0]         rdata_reg;
  logic [N_PIN-1:0]    pin_out_reg, pin_oe_reg;
  logic [N_FUNC-1:0]   periph_in_reg;
  logic [N_IRQ-1:0]    irq_reg;

  logic [N_PIN-1:0]    pin_out_next, pin_oe_next;
  logic [N_FUNC-1:0]   periph_in_next;
  logic [N_IRQ-1:0]    irq_next;
  logic [FW:0]         route_w [N_PIN];
  logic [7:0]          mask_w  [N_PIN];

  wire logic [4:0] wr_dec    = reg_decode(awaddr_reg);
  wire logic [4:0] rd_dec    = reg_decode(s_axi_araddr_i);
  wire logic       wr_go     = aw_held_reg && w_held_reg && (wr_state_reg == WR_IDLE);
  wire logic       aw_take   = s_axi_awvalid_i && awready_reg;
  wire logic       w_take    = s_axi_wvalid_i && wready_reg;
  wire logic       ar_take   = s_axi_arvalid_i && arready_reg;
  wire logic [7:0] rd_value  = rd_dec[4] ? ctrl_reg[rd_dec[3:0]] : 8'h00;

  genvar g;
  generate
    for (g = 0; g < N_PIN; g++) begin : g_pin
      assign route_w[g]      = pin_route(4'(g), ctrl_reg[g][SEL_MSB:0]);
      assign mask_w[g]       = (4'(g) >= PIN_P30) ? MASK_P3 : MASK_P12;
      assign pin_out_next[g] = route_w[g][FW] && periph_out_i[route_w[g][FW-1:0]];
      assign pin_oe_next[g]  = route_w[g][FW] && periph_oe_i[route_w[g][FW-1:0]];
    end
  endgenerate

  // Pin inputs back to the selected peripherals and to the interrupt lines
  always_comb begin
    logic [3:0] irq_sel;
    irq_sel        = 4'h0;
    periph_in_next = '0;
    irq_next       = '0;
    for (int p = 0; p < N_PIN; p++) begin
      irq_sel = pin_irq(4'(p));
      if (route_w[p][FW]) begin
        periph_in_next[route_w[p][FW-1:0]] = periph_in_next[route_w[p][FW-1:0]] | pin_in_i[p];
      end
      if (ctrl_reg[p][IRQ_INPUT_SELECT_BIT] && irq_sel[3]) begin
        irq_next[irq_sel[2:0]] = irq_next[irq_sel[2:0]] | pin_in_i[p];
      end
    end
  end

  // Control registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int p = 0; p < N_PIN; p++) ctrl_reg[p] <= CTRL_RST;
    end else if (ce_i && wr_go && wr_dec[4] && wstrb0_reg) begin
      ctrl_reg[wr_dec[3:0]] <= wdata_reg & mask_w[wr_dec[3:0]];
    end
  end

  // Write channel
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_state_reg <= WR_IDLE;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
    end else if (ce_i) begin
      case (wr_state_reg)
        WR_IDLE: begin
          awready_reg <= !aw_held_reg && !aw_take;
          wready_reg  <= !w_held_reg && !w_take;
          if (aw_take) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr_i;
          end
          if (w_take) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_i[7:0];
            wstrb0_reg <= s_axi_wstrb_i[0];
          end
          if (wr_go) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            bvalid_reg   <= 1'b1;
            bresp_reg    <= wr_dec[4] ? RESP_OKAY : RESP_SLV;
            wr_state_reg <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready_i) begin
            bvalid_reg   <= 1'b0;
            wr_state_reg <= WR_IDLE;
          end
        end
        default: wr_state_reg <= WR_IDLE;
      endcase
    end
  end

  // Read channel
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_state_reg <= RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= '0;
      rresp_reg    <= RESP_OKAY;
    end else if (ce_i) begin
      case (rd_state_reg)
        RD_IDLE: begin
          arready_reg <= !ar_take;
          if (ar_take) begin
            rvalid_reg   <= 1'b1;
            rdata_reg    <= {24'h000000, rd_value};
            rresp_reg    <= rd_dec[4] ? RESP_OKAY : RESP_SLV;
            rd_state_reg <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (s_axi_rready_i) begin
            rvalid_reg   <= 1'b0;
            arready_reg  <= 1'b1;
            rd_state_reg <= RD_IDLE;
          end
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  // Registered pin and peripheral side
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out_reg   <= '0;
      pin_oe_reg    <= '0;
      periph_in_reg <= '0;
      irq_reg       <= '0;
    end else if (ce_i) begin
      pin_out_reg   <= pin_out_next;
      pin_oe_reg    <= pin_oe_next;
      periph_in_reg <= periph_in_next;
      irq_reg       <= irq_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign pin_out_o       = pin_out_reg;
  assign pin_oe_o        = pin_oe_reg;
  assign periph_in_o     = periph_in_reg;
  assign irq_o           = irq_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_hiz;
    ce_i && ctrl_reg[PIN_P13][SEL_MSB:0] == CODE_HIZ |=> !pin_oe_o[PIN_P13];
  endproperty
  a_hiz: assert property (p_hiz) else $error("unassigned pin drives");

  property p_p13_mt;
    ce_i && ctrl_reg[PIN_P13][SEL_MSB:0] == CODE_MT1
      |=> pin_out_o[PIN_P13] == $past(periph_out_i[F_CH0_B]);
  endproperty
  a_p13_mt: assert property (p_p13_mt) else $error("pin 13 timer route wrong");

  property p_p14_can;
    ce_i && ctrl_reg[PIN_P14][SEL_MSB:0] == CODE_CAN
      |=> pin_oe_o[PIN_P14] == $past(periph_oe_i[F_CAN_TX]);
  endproperty
  a_p14_can: assert property (p_p14_can) else $error("pin 14 CAN route wrong");

  property p_p15_rx;
    ce_i && ctrl_reg[PIN_P15][SEL_MSB:0] == CODE_SCA && ctrl_reg[PIN_P30][SEL_MSB:0] != CODE_SCA
      |=> periph_in_o[F_S1_RX] == $past(pin_in_i[PIN_P15]);
  endproperty
  a_p15_rx: assert property (p_p15_rx) else $error("pin 15 serial input wrong");

  property p_p16_rtc;
    ce_i && ctrl_reg[PIN_P16][SEL_MSB:0] == CODE_ALT
      |=> pin_out_o[PIN_P16] == $past(periph_out_i[F_RTC]);
  endproperty
  a_p16_rtc: assert property (p_p16_rtc) else $error("pin 16 clock out wrong");

  property p_p26_lpt;
    ce_i && ctrl_reg[PIN_P26][SEL_MSB:0] == CODE_LPT
      |=> pin_out_o[PIN_P26] == $past(periph_out_i[F_LOWPOWER_TIMER_OUTPUT]);
  endproperty
  a_p26_lpt: assert property (p_p26_lpt) else $error("pin 26 timer out wrong");

  property p_p36_irq;
    ce_i && ctrl_reg[PIN_P36][IRQ_INPUT_SELECT_BIT] && pin_in_i[PIN_P36] |=> irq_o[2];
  endproperty
  a_p36_irq: assert property (p_p36_irq) else $error("pin 36 irq lost");

  property p_irq_off;
    ce_i && !ctrl_reg[PIN_P32][IRQ_INPUT_SELECT_BIT] && !ctrl_reg[PIN_P36][IRQ_INPUT_SELECT_BIT] |=> !irq_o[2];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq 2 without select");

  property p_no_analog;
    ctrl_reg[PIN_P14][7:5] == 3'h0 && ctrl_reg[PIN_P27][7:5] == 3'h0;
  endproperty
  a_no_analog: assert property (p_no_analog) else $error("port 1/2 upper bits set");

  property p_reserved;
    ce_i |=> !pin_oe_o[PIN_P36] && !pin_oe_o[PIN_P37];
  endproperty
  a_reserved: assert property (p_reserved) else $error("pin without functions drives");

  c_write: cover property (bvalid_reg && s_axi_bready_i && bresp_reg == RESP_OKAY);
  c_read: cover property (rvalid_reg && s_axi_rready_i && rdata_reg != 32'h0);
  c_irq: cover property (irq_o[4]);
  c_drive: cover property (pin_oe_o[PIN_P16] ##1 !pin_oe_o[PIN_P16]);

endmodule : ppm_pin_mux

// [inc/ppm_pkg.sv]
// Constants for the port pin function multiplexer
package ppm_pkg;
  localparam int unsigned N_PIN    = 15;
  localparam int unsigned N_FUNC   = 48;
  localparam int unsigned N_IRQ    = 5;
  localparam int unsigned FW       = 6;
  localparam int unsigned AXI_AW   = 8;
  // Register map: one word per pin, in pin order
  localparam logic [AXI_AW-1:0] REG_BASE  = 8'h00;
  localparam int unsigned       REG_SHIFT = 2;
  localparam logic [1:0]        RESP_OKAY = 2'h0;
  localparam logic [1:0]        RESP_SLV  = 2'h2;
  // Control register fields
  localparam int unsigned  SEL_MSB   = 4;
  localparam int unsigned  IRQ_INPUT_SELECT_BIT  = 6;
  localparam logic [7:0]   MASK_P12  = 8'h1F;
  localparam logic [7:0]   MASK_P3   = 8'h5F;
  localparam logic [7:0]   CTRL_RST  = 8'h00;
  // Pin indices
  localparam logic [3:0] PIN_P13 = 4'h0;
  localparam logic [3:0] PIN_P14 = 4'h1;
  localparam logic [3:0] PIN_P15 = 4'h2;
  localparam logic [3:0] PIN_P16 = 4'h3;
  localparam logic [3:0] PIN_P17 = 4'h4;
  localparam logic [3:0] PIN_P20 = 4'h5;
  localparam logic [3:0] PIN_P21 = 4'h6;
  localparam logic [3:0] PIN_P26 = 4'h7;
  localparam logic [3:0] PIN_P27 = 4'h8;
  localparam logic [3:0] PIN_P30 = 4'h9;
  localparam logic [3:0] PIN_P31 = 4'hA;
  localparam logic [3:0] PIN_P32 = 4'hB;
  localparam logic [3:0] PIN_P34 = 4'hC;
  localparam logic [3:0] PIN_P36 = 4'hD;
  localparam logic [3:0] PIN_P37 = 4'hE;
  // Function codes
  localparam logic [4:0] CODE_HIZ = 5'h00;
  localparam logic [4:0] CODE_MT1 = 5'h01;
  localparam logic [4:0] CODE_MT2 = 5'h02;
  localparam logic [4:0] CODE_TMR = 5'h05;
  localparam logic [4:0] CODE_ALT = 5'h07;
  localparam logic [4:0] CODE_ADT = 5'h09;
  localparam logic [4:0] CODE_SCA = 5'h0A;
  localparam logic [4:0] CODE_SCB = 5'h0B;
  localparam logic [4:0] CODE_SPI = 5'h0D;
  localparam logic [4:0] CODE_IIC = 5'h0F;
  localparam logic [4:0] CODE_TS  = 5'h19;
  localparam logic [4:0] CODE_LPT = 5'h1B;
  localparam logic [4:0] CODE_CAN = 5'h1C;
  // Peripheral function indices
  localparam logic [5:0] F_CH0_A = 6'h00, F_CH0_B = 6'h01, F_CH0_C = 6'h02;
  localparam logic [5:0] F_CH1_A = 6'h03, F_CH1_B = 6'h04, F_CH2_A = 6'h05;
  localparam logic [5:0] F_CH2_B = 6'h06, F_CH3_A = 6'h07, F_CH3_B = 6'h08;
  localparam logic [5:0] F_CH3_C = 6'h09, F_CH3_D = 6'h0A, F_CH4_B = 6'h0B;
  localparam logic [5:0] F_CH4_D = 6'h0C, F_CLK_A = 6'h0D, F_CLK_B = 6'h0E;
  localparam logic [5:0] F_T0_RST = 6'h0F, F_T0_CNT = 6'h10, F_T1_OUT = 6'h11;
  localparam logic [5:0] F_T2_CNT = 6'h12, F_T2_RST = 6'h13, F_T2_OUT = 6'h14;
  localparam logic [5:0] F_T3_OUT = 6'h15, F_T3_CNT = 6'h16, F_T3_RST = 6'h17;
  localparam logic [5:0] F_ODIS8 = 6'h18, F_ODIS2 = 6'h19, F_S1_RX = 6'h1A;
  localparam logic [5:0] F_S1_TX = 6'h1B, F_S1_CLK = 6'h1C, F_S1_FLOW = 6'h1D;
  localparam logic [5:0] F_S6_TX = 6'h1E, F_S6_CLK = 6'h1F, F_SPI_MO = 6'h20;
  localparam logic [5:0] F_SPI_MI = 6'h21, F_RTC = 6'h22, F_ADTRG = 6'h23;
  localparam logic [5:0] F_CAN_TX = 6'h24, F_CAN_RX = 6'h25, F_LOWPOWER_TIMER_OUTPUT = 6'h26;
  localparam logic [5:0] F_TS0 = 6'h27, F_TS1 = 6'h28, F_TS2 = 6'h29;
  localparam logic [5:0] F_TS3 = 6'h2A, F_TS4 = 6'h2B, F_TS5 = 6'h2C;
  localparam logic [5:0] F_TS6 = 6'h2D, F_SDA = 6'h2E, F_SCL = 6'h2F;
  // Write channel and read channel states
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} ppm_wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} ppm_rd_state_t;
endpackage : ppm_pkg

// [sim/ppm_tb.sv]
// Self-checking testbench for the port pin function multiplexer
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module testbench
  import ppm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk = 1'b0, reset_n = 1'b0, ce = 1'b1;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        wstrb = '0;
  logic [1:0]        bresp, rresp;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic              rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [N_PIN-1:0]  pin_in = '1, pin_out, pin_oe, exp_pin;
  logic [N_FUNC-1:0] p_out = '1, p_oe = '1, p_in;
  logic [N_IRQ-1:0]  irq;
  logic [15:0]       e;
  int                n_errors = 0, checks_done = 0;
  int                irqn [6] = '{0, 1, 2, 4, 2, 4};
  // Pin, code, function, drives out; function 3F marks a reserved code
  logic [15:0]       tbl [64] = '{
    16'h0083, 16'h02AB, 16'h07DD,
    16'h017F, 16'h0E7F, 16'hD0FF,
    16'h108F, 16'h111A, 16'h12A6, 16'h15BB, 16'h1CDB, 16'h1E49,
    16'h2083, 16'h211C, 16'h22A4, 16'h2534, 16'h2CD9, 16'h2E4A,
    16'h3093, 16'h3115, 16'h32A9, 16'h33C5, 16'h34C6, 16'h3537, 16'h36C1, 16'h37DF,
    16'h408F, 16'h4111, 16'h42A3, 16'h43B0, 16'h4539, 16'h46C2, 16'h47DD,
    16'h5087, 16'h529E, 16'h6089, 16'h62A0,
    16'h708B, 16'h72A3, 16'h7537, 16'h7CD7, 16'h7DCD,
    16'h808D, 16'h82AC, 16'h8539, 16'h8CD5,
    16'h9097, 16'h92AE, 16'h93B0, 16'h9534, 16'h9CD3,
    16'hA099, 16'hA2A4, 16'hA53B, 16'hACD1,
    16'hB085, 16'hB2AB, 16'hB3C5, 16'hB5BD, 16'hBCCF,
    16'hC081, 16'hC2AC, 16'hC3B2, 16'hC5BF
  };

  ppm_pin_mux dut (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .ce_i(ce),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .periph_out_i(p_out), .periph_oe_i(p_oe),
    .periph_in_o(p_in), .irq_o(irq)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      aw_ok |= (awready === 1'b1);
      w_ok |= (wready === 1'b1);
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    `CHK(bresp, r)
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    `CHK(rdata, d)
    `CHK(rresp, r)
    rready <= 1'b0;
  endtask : axi_rd

  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial begin
    #300000;
    n_errors++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(pin_oe, 15'h0)
    `CHK(p_in, 48'h0)
    `CHK(irq, 5'h0)
    for (int i = 0; i < N_PIN; i++) begin
      axi_rd(8'(i * 4), 32'h0, RESP_OKAY);
      axi_wr(8'(i * 4), 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      axi_rd(8'(i * 4), (i < 9) ? 32'h1F : 32'h5F, RESP_OKAY);
      axi_wr(8'(i * 4), 32'h0, 4'hF, RESP_OKAY);
    end
    // Byte lane 0 off: write has no effect
    axi_wr(8'h00, 32'h0000_000F, 4'hE, RESP_OKAY);
    axi_rd(8'h00, 32'h0, RESP_OKAY);
    axi_wr(8'h3C, 32'h0000_0001, 4'hF, RESP_SLV);
    axi_rd(8'h3C, 32'h0, RESP_SLV);
    foreach (tbl[k]) begin
      e = tbl[k];
      axi_wr({2'b00, e[15:12], 2'b00}, {27'h0, e[11:7]}, 4'hF, RESP_OKAY);
      pin_in <= 15'h1 << e[15:12];
      p_out <= {N_FUNC{e[0]}};
      p_oe <= {N_FUNC{e[0]}};
      repeat (4) @(posedge sys_clk);
      exp_pin = (e[0] && e[6:1] != 6'h3F) ? 15'h1 << e[15:12] : 15'h0;
      `CHK(pin_oe, exp_pin)
      `CHK(pin_out, exp_pin)
      `CHK(p_in, (e[6:1] == 6'h3F) ? 48'h0 : 48'h1 << e[6:1])
      axi_wr({2'b00, e[15:12], 2'b00}, 32'h0, 4'hF, RESP_OKAY);
    end
    p_oe <= '0;
    pin_in <= '1;
    for (int i = 0; i < 6; i++) begin
      axi_wr(8'((9 + i) * 4), 32'h40, 4'hF, RESP_OKAY);
      repeat (4) @(posedge sys_clk);
      `CHK(irq, 5'h1 << irqn[i])
      axi_wr(8'((9 + i) * 4), 32'h0, 4'hF, RESP_OKAY);
      repeat (4) @(posedge sys_clk);
      `CHK(irq, 5'h0)
    end
    `CHK(pin_oe, 15'h0)
    // Clock enable low freezes the pin side
    axi_wr(8'h24, 32'h40, 4'hF, RESP_OKAY);
    ce <= 1'b0;
    pin_in <= '0;
    repeat (4) @(posedge sys_clk);
    `CHK(irq, 5'h01)
    ce <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(irq, 5'h00)
    // Reset in mid-run clears the control registers
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    axi_rd(8'h24, 32'h0, RESP_OKAY);
    close_out();
  end
endmodule : testbench
